/* src/board_reset_pkg.sv */
/*
 Constants, register map and state encoding for the board reset and
 front-panel control block. Assumes one 40 MHz clock.
*/
package board_reset_pkg;
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int SYSRESET_MIN_MS = 200;
    localparam int SYSRESET_CYCLES = SYSRESET_MIN_MS * (CLK_FREQ_HZ / 1000);
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_FREQ_HZ / 1000);
    localparam int BUS_TIMEOUT_US = 100;
    localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int CNT_W = 24;
    localparam int TO_W = 13;

    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LOC_MON = 4'h8;

    localparam int CTRL_LOCAL_RESET = 0;
    localparam int CTRL_SYS_RESET = 1;
    localparam int CTRL_ABORT_EN = 2;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    localparam logic [3:0] LOC_MON_RESET = 4'h0;
    localparam logic [5:0] SYNC_RESET = 6'h2F;

    localparam logic [1:0] SPACE_A32 = 2'h0;
    localparam logic [1:0] SPACE_A16 = 2'h1;
    localparam logic [1:0] SPACE_A24 = 2'h2;
    localparam logic [15:0] A16_TOP = 16'hFFFF;
    localparam logic [7:0] A24_TOP = 8'hF0;

    typedef enum logic [1:0] {
        SR_IDLE = 2'h0,
        SR_HOLD = 2'h1,
        SR_DRAIN = 2'h3
    } sysrst_state_e;
endpackage : board_reset_pkg

/* src/board_reset_ctrl.sv */
/*
 Board reset generation, backplane system reset, abort interrupt,
 front-panel lamps, location monitors and backplane timeout.
 Assumes pins are asynchronous and bus-side status comes from core_clk_in logic.
*/
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module board_reset_ctrl
    import board_reset_pkg::*;
#(
    parameter int SYSRESET_LEN = SYSRESET_CYCLES,
    parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic reset_button_n_in,
    input wire logic abort_button_n_in,
    input wire logic sys_ctrl_strap_n_in,
    input wire logic sysreset_n_in,
    output logic sysreset_n_out,
    output logic sysreset_oe_n_out,
    input wire logic watchdog_timeout_in,
    input wire logic board_failure_signal_in,
    input wire logic cpu_cycle_status_n_in,
    input wire logic lan_bus_master_in,
    input wire logic scsi_bus_master_in,
    input wire logic vme_master_cycle_in,
    input wire logic vme_slave_access_in,
    input wire logic vme_cycle_pending_in,
    input wire logic vme_cycle_ack_in,
    input wire logic [31:0] vme_access_addr_in,
    output logic board_reset_out,
    output logic memory_reset_out,
    output logic nmi_out,
    output logic fail_lamp_out,
    output logic controller_role_lamp_out,
    output logic run_lamp_out,
    output logic lan_lamp_out,
    output logic scsi_lamp_out,
    output logic vme_lamp_out,
    output logic bus_timeout_out,
    output logic [1:0] vme_addr_space_out,
    output logic [3:0] loc_monitor_out
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [CNT_W:0] debounce_next(
        input logic raw,
        input logic state,
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] limit
    );
        logic [CNT_W:0] res;
        res = {state, {CNT_W{1'b0}}};
        if (raw != state) begin
            if (cnt == limit - 1'b1) begin
                res = {raw, {CNT_W{1'b0}}};
            end else begin
                res = {state, cnt + 1'b1};
            end
        end
        return res;
    endfunction : debounce_next

    function automatic logic [1:0] addr_space(input logic [31:0] addr);
        logic [1:0] sp;
        sp = SPACE_A32;
        if (addr[31:16] == A16_TOP) begin
            sp = SPACE_A16;
        end else if (addr[31:24] == A24_TOP) begin
            sp = SPACE_A24;
        end
        return sp;
    endfunction : addr_space

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] sync1;
    logic [5:0] sync2;
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sync1 <= SYNC_RESET;
            sync2 <= SYNC_RESET;
        end else if (ce_in) begin
            sync1 <= {cpu_cycle_status_n_in, board_failure_signal_in, sysreset_n_in,
                      sys_ctrl_strap_n_in, abort_button_n_in, reset_button_n_in};
            sync2 <= sync1;
        end
    end

    logic sys_ctrl;
    logic sysrst_seen;
    assign sys_ctrl = ~sync2[2];
    assign sysrst_seen = ~sync2[3];

    // ------------------------------------------------------------
    // Button debouncers
    // ------------------------------------------------------------
    logic btn_db, next_btn_db, abt_db, next_abt_db;
    logic [CNT_W-1:0] btn_cnt, next_btn_cnt, abt_cnt, next_abt_cnt;
    always_comb begin
        {next_btn_db, next_btn_cnt} = debounce_next(~sync2[0], btn_db, btn_cnt,
                                                    CNT_W'(DEBOUNCE_LEN));
        {next_abt_db, next_abt_cnt} = debounce_next(~sync2[1], abt_db, abt_cnt,
                                                    CNT_W'(DEBOUNCE_LEN));
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            btn_db <= 1'b0;
            btn_cnt <= '0;
            abt_db <= 1'b0;
            abt_cnt <= '0;
        end else if (ce_in) begin
            btn_db <= next_btn_db;
            btn_cnt <= next_btn_cnt;
            abt_db <= next_abt_db;
            abt_cnt <= next_abt_cnt;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [2:0] control, next_control;
    logic [3:0] loc_mon, next_loc_mon;
    logic [31:0] next_rdata;
    sysrst_state_e sr_state, next_sr_state;
    always_comb begin
        next_control = control;
        next_loc_mon = loc_mon;
        next_rdata = 32'h0000_0000;
        if (reg_wr_in) begin
            case (reg_addr_in)
                REG_CONTROL: next_control = reg_wdata_in[2:0];
                REG_LOC_MON: next_loc_mon = reg_wdata_in[3:0];
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_CONTROL: next_rdata = {29'h0, control};
                REG_STATUS: next_rdata = {27'h0, sysrst_seen, abt_db,
                                          sr_state != SR_IDLE, board_reset_out, sys_ctrl};
                REG_LOC_MON: next_rdata = {28'h0, loc_mon};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            control <= CONTROL_RESET;
            loc_mon <= LOC_MON_RESET;
            reg_rdata_out <= 32'h0000_0000;
        end else if (ce_in) begin
            control <= next_control;
            loc_mon <= next_loc_mon;
            reg_rdata_out <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // System reset sequencer
    // ------------------------------------------------------------
    logic pwr_pending, next_pwr_pending;
    logic [CNT_W-1:0] sr_cnt, next_sr_cnt;
    logic sr_src;
    logic sr_done;
    // Power-up start waits until the strap has crossed the synchronisers
    logic [1:0] sync_fill, next_sync_fill;
    logic sync_ready;
    assign sync_ready = sync_fill[1];
    assign sr_src = btn_db | (pwr_pending & sync_ready) | watchdog_timeout_in | control[CTRL_SYS_RESET];
    assign sr_done = sr_cnt == CNT_W'(SYSRESET_LEN - 1);
    always_comb begin
        next_sr_state = sr_state;
        next_sr_cnt = sr_cnt;
        next_pwr_pending = pwr_pending;
        next_sync_fill = {sync_fill[0], 1'b1};
        case (sr_state)
            SR_IDLE: begin
                next_sr_cnt = '0;
                if (sr_src) begin
                    next_sr_state = SR_HOLD;
                    next_pwr_pending = 1'b0;
                end
            end
            SR_HOLD: begin
                next_sr_cnt = sr_cnt + 1'b1;
                if (sr_done) begin
                    next_sr_cnt = '0;
                    next_sr_state = sr_src ? SR_DRAIN : SR_IDLE;
                end
            end
            SR_DRAIN: begin
                if (!sr_src) begin
                    next_sr_state = SR_IDLE;
                end
            end
            default: begin
                next_sr_state = SR_IDLE;
                next_sr_cnt = '0;
            end
        endcase
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sr_state <= SR_IDLE;
            sr_cnt <= '0;
            pwr_pending <= 1'b1;
            sync_fill <= 2'h0;
        end else if (ce_in) begin
            sr_state <= next_sr_state;
            sync_fill <= next_sync_fill;
            sr_cnt <= next_sr_cnt;
            pwr_pending <= next_pwr_pending;
        end
    end

    // ------------------------------------------------------------
    // Resets, interrupt, lamps and bus status
    // ------------------------------------------------------------
    logic sr_active;
    logic mem_other;
    logic next_drive, next_board_reset, next_mem_reset, next_nmi;
    logic [TO_W-1:0] to_cnt, next_to_cnt;
    logic next_timeout;
    assign sr_active = sr_state != SR_IDLE;
    assign mem_other = pwr_pending | watchdog_timeout_in | sysrst_seen | control[CTRL_LOCAL_RESET];
    always_comb begin
        next_drive = sys_ctrl & sr_active;
        next_board_reset = sr_active | btn_db | mem_other;
        next_mem_reset = mem_other | (sys_ctrl & (sr_active | btn_db));
        next_nmi = abt_db & control[CTRL_ABORT_EN];
        next_to_cnt = '0;
        next_timeout = 1'b0;
        if (vme_cycle_pending_in && !vme_cycle_ack_in && sys_ctrl) begin
            next_to_cnt = to_cnt + 1'b1;
            if (to_cnt == TO_W'(BUS_TIMEOUT_CYCLES - 1)) begin
                next_to_cnt = '0;
                next_timeout = 1'b1;
            end
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sysreset_n_out <= 1'b1;
            sysreset_oe_n_out <= 1'b1;
            board_reset_out <= 1'b1;
            memory_reset_out <= 1'b1;
            nmi_out <= 1'b0;
            fail_lamp_out <= 1'b0;
            controller_role_lamp_out <= 1'b0;
            run_lamp_out <= 1'b0;
            lan_lamp_out <= 1'b0;
            scsi_lamp_out <= 1'b0;
            vme_lamp_out <= 1'b0;
            bus_timeout_out <= 1'b0;
            to_cnt <= '0;
            vme_addr_space_out <= SPACE_A32;
            loc_monitor_out <= LOC_MON_RESET;
        end else if (ce_in) begin
            sysreset_n_out <= ~next_drive;
            sysreset_oe_n_out <= ~next_drive;
            board_reset_out <= next_board_reset;
            memory_reset_out <= next_mem_reset;
            nmi_out <= next_nmi;
            fail_lamp_out <= sync2[4];
            controller_role_lamp_out <= sys_ctrl;
            run_lamp_out <= ~sync2[5];
            lan_lamp_out <= lan_bus_master_in;
            scsi_lamp_out <= scsi_bus_master_in;
            vme_lamp_out <= vme_master_cycle_in | vme_slave_access_in;
            bus_timeout_out <= next_timeout;
            to_cnt <= next_to_cnt;
            vme_addr_space_out <= addr_space(vme_access_addr_in);
            loc_monitor_out <= loc_mon;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence sr_start_s;
        sr_state == SR_IDLE && sr_src && ce_in;
    endsequence
    sequence sr_enter_s;
        sr_state == SR_HOLD && sr_cnt == '0;
    endsequence
    sequence sr_power_s;
        sr_state == SR_IDLE && pwr_pending && sync_ready && ce_in;
    endsequence

    sysrst_start_a: assert property (sr_start_s |=> sr_enter_s)
        else $error("backplane reset did not start");
    sysrst_min_a: assert property ($past(sr_state) == SR_HOLD && sr_state != SR_HOLD
        |-> $past(sr_cnt) == CNT_W'(SYSRESET_LEN - 1))
        else $error("backplane reset left hold early");
    sysrst_owner_a: assert property ($past(ce_in) && !sysreset_oe_n_out
        |-> $past(sys_ctrl) && $past(sr_active))
        else $error("backplane reset driven without controller role");
    board_rst_src_a: assert property (ce_in && (btn_db || sysrst_seen || watchdog_timeout_in)
        |=> board_reset_out)
        else $error("board reset missing for active source");
    local_hold_a: assert property (ce_in && control[CTRL_LOCAL_RESET]
        |=> board_reset_out && memory_reset_out)
        else $error("local reset bit not holding board");
    mem_spare_a: assert property (ce_in && !sys_ctrl && !mem_other
        |=> !memory_reset_out)
        else $error("memory reset without own cause");
    abort_nmi_a: assert property ($past(ce_in) && nmi_out
        |-> $past(abt_db) && $past(control[CTRL_ABORT_EN]))
        else $error("nmi without enabled abort");
    ctrl_lamp_a: assert property ($past(ce_in) |-> controller_role_lamp_out == $past(sys_ctrl))
        else $error("controller lamp mismatch");
    no_timeout_a: assert property (ce_in && !sys_ctrl |=> !bus_timeout_out)
        else $error("timeout raised while not controller");
    vme_lamp_a: assert property ($past(ce_in) && vme_lamp_out
        |-> $past(vme_master_cycle_in || vme_slave_access_in))
        else $error("vme lamp without backplane activity");
    sysrst_power_a: assert property (sr_power_s |=> sr_enter_s)
        else $error("power-up backplane reset did not start");
    sysrst_drive_a: assert property (ce_in && sys_ctrl && sr_active
        |=> !sysreset_oe_n_out && !sysreset_n_out)
        else $error("backplane reset not driven as controller");
    btn_board_a: assert property (ce_in && btn_db && sys_ctrl
        |=> board_reset_out && memory_reset_out)
        else $error("button reset incomplete as controller");
    drain_end_a: assert property (ce_in && sr_state == SR_DRAIN && !sr_src
        |=> sr_state == SR_IDLE)
        else $error("backplane reset held after sources cleared");
    all_clear_a: assert property ($past(ce_in) && !$past(rst_in) && !board_reset_out
        |-> !$past(sr_active) && !$past(btn_db) && !$past(mem_other))
        else $error("board reset released with a source active");
    nmi_set_a: assert property (ce_in && abt_db && control[CTRL_ABORT_EN]
        |=> nmi_out)
        else $error("enabled abort without nmi");
    timeout_pulse_a: assert property (ce_in && bus_timeout_out |=> !bus_timeout_out)
        else $error("bus timeout longer than one cycle");

    // ------------------------------------------------------------
    // Lamp, monitor and address space checks
    // ------------------------------------------------------------
    fail_lamp_a: assert property ($past(ce_in) && !$past(rst_in)
        |-> fail_lamp_out == $past(sync2[4]))
        else $error("fail lamp mismatch");
    run_lamp_a: assert property ($past(ce_in) && !$past(rst_in)
        |-> run_lamp_out == !$past(sync2[5]))
        else $error("run lamp mismatch");
    lan_lamp_a: assert property ($past(ce_in) && !$past(rst_in)
        |-> lan_lamp_out == $past(lan_bus_master_in))
        else $error("lan lamp mismatch");
    scsi_lamp_a: assert property ($past(ce_in) && !$past(rst_in)
        |-> scsi_lamp_out == $past(scsi_bus_master_in))
        else $error("scsi lamp mismatch");
    loc_mon_a: assert property ($past(ce_in) && !$past(rst_in)
        |-> loc_monitor_out == $past(loc_mon))
        else $error("location monitor mismatch");
    space_a16_a: assert property ($past(ce_in) && !$past(rst_in) && $past(vme_access_addr_in[31:16]) == A16_TOP
        |-> vme_addr_space_out == SPACE_A16)
        else $error("short address window not decoded");
    space_a24_a: assert property ($past(ce_in) && !$past(rst_in) && $past(vme_access_addr_in[31:24]) == A24_TOP
        |-> vme_addr_space_out == SPACE_A24)
        else $error("standard address window not decoded");
endmodule : board_reset_ctrl
`default_nettype wire

/* tb/vme_backplane_model.sv */
/*
 Backplane partner: open-drain reset wire with pull-up, other boards'
 reset pulls, and a slave that acknowledges only when one is present.
 Assumes the same clock and reset as the block under test.
*/
`timescale 1ns/10ps
`default_nettype none
module vme_backplane_model #(
    parameter int ACK_DELAY = 3
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic drive_level_in,
    input wire logic drive_oe_n_in,
    input wire logic other_reset_in,
    input wire logic slot_present_in,
    input wire logic cycle_pending_in,
    output logic wire_level_out,
    output logic cycle_ack_out
);
    logic [7:0] wait_cnt;
    logic [7:0] next_wait_cnt;
    logic next_ack;
    // Pull-up wins once every driver has let go
    assign wire_level_out = ~other_reset_in & (drive_oe_n_in | drive_level_in);
    always_comb begin
        next_wait_cnt = (cycle_pending_in && wait_cnt != 8'hFF) ? wait_cnt + 8'h01 : wait_cnt;
        if (!cycle_pending_in) begin
            next_wait_cnt = 8'h00;
        end
        // Empty slot never answers
        next_ack = cycle_pending_in & slot_present_in & (wait_cnt >= 8'(ACK_DELAY));
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wait_cnt <= 8'h00;
            cycle_ack_out <= 1'h0;
        end else begin
            wait_cnt <= next_wait_cnt;
            cycle_ack_out <= next_ack;
        end
    end
endmodule : vme_backplane_model
`default_nettype wire

/* tb/board_reset_and_panel_control_tb.sv */
/*
 Self-checking bench for the board reset and front-panel block.
 Assumes short reset and debounce counts set through parameters.
*/
`timescale 1ns/10ps
`default_nettype none
module board_reset_and_panel_control_tb;
    import board_reset_pkg::*;
    localparam int SR = 20;
    localparam int DB = 4;
    logic core_clk_in = 1'h0, rst_in = 1'h1, ce_in = 1'h1, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0, vme_access_addr_in = 32'h0, reg_rdata_out;
    logic reset_button_n_in = 1'h1, abort_button_n_in = 1'h1, sys_ctrl_strap_n_in = 1'h0;
    logic watchdog_timeout_in = 1'h0, board_failure_signal_in = 1'h0, cpu_cycle_status_n_in = 1'h1;
    logic lan_bus_master_in = 1'h0, scsi_bus_master_in = 1'h0, vme_master_cycle_in = 1'h0;
    logic vme_slave_access_in = 1'h0, vme_cycle_pending_in = 1'h0, other_reset = 1'h0, slot_present = 1'h0;
    logic sysreset_n_in, sysreset_n_out, sysreset_oe_n_out, vme_cycle_ack_in, board_reset_out;
    logic memory_reset_out, nmi_out, fail_lamp_out, controller_role_lamp_out, run_lamp_out;
    logic lan_lamp_out, scsi_lamp_out, vme_lamp_out, bus_timeout_out;
    logic [1:0] vme_addr_space_out;
    logic [3:0] loc_monitor_out;
    int n_mismatch = 0, num_checks = 0, nr, nd, nm;

    always #12.5 core_clk_in = ~core_clk_in;

    board_reset_ctrl #(.SYSRESET_LEN(SR), .DEBOUNCE_LEN(DB)) board_reset_ctrl_i (.core_clk_in, .rst_in,
        .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .reset_button_n_in,
        .abort_button_n_in, .sys_ctrl_strap_n_in, .sysreset_n_in, .sysreset_n_out, .sysreset_oe_n_out,
        .watchdog_timeout_in, .board_failure_signal_in, .cpu_cycle_status_n_in, .lan_bus_master_in,
        .scsi_bus_master_in, .vme_master_cycle_in, .vme_slave_access_in, .vme_cycle_pending_in,
        .vme_cycle_ack_in, .vme_access_addr_in, .board_reset_out, .memory_reset_out, .nmi_out,
        .fail_lamp_out, .controller_role_lamp_out, .run_lamp_out, .lan_lamp_out, .scsi_lamp_out,
        .vme_lamp_out, .bus_timeout_out, .vme_addr_space_out, .loc_monitor_out);

    vme_backplane_model vme_backplane_model_i (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .drive_level_in(sysreset_n_out), .drive_oe_n_in(sysreset_oe_n_out), .other_reset_in(other_reset),
        .slot_present_in(slot_present), .cycle_pending_in(vme_cycle_pending_in),
        .wire_level_out(sysreset_n_in), .cycle_ack_out(vme_cycle_ack_in));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task chk_min(input int got, input int lo);
        num_checks++;
        if (got < lo) begin
            n_mismatch++;
            $display("Error t=%0t got=%h min=%h", $time, got, lo);
        end
    endtask : chk_min
    task tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : tick
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_wr_in <= 1'h1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in <= 1'h0;
    endtask : wr
    task rd_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk_in);
        reg_rd_in <= 1'h1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in <= 1'h0;
        #1 chk(reg_rdata_out, e);
    endtask : rd_chk
    // Counts reset cycles until board and backplane reset are both released
    task meas;
        nr = 0;
        nd = 0;
        nm = 0;
        for (int i = 0; i < 300; i++) begin
            tick(1);
            nr += int'(board_reset_out === 1'h1);
            nd += int'(sysreset_oe_n_out === 1'h0 && sysreset_n_out === 1'h0);
            nm += int'(memory_reset_out === 1'h1);
            if (i > 16 && board_reset_out === 1'h0 && sysreset_oe_n_out === 1'h1) break;
        end
    endtask : meas
    task fire(input int s);
        @(posedge core_clk_in);
        if (s == 0) begin
            watchdog_timeout_in <= 1'h1;
            @(posedge core_clk_in);
            watchdog_timeout_in <= 1'h0;
        end else if (s == 1) begin
            wr(REG_CONTROL, 32'h1 << CTRL_SYS_RESET);
            wr(REG_CONTROL, 32'h0);
        end else if (s == 2) begin
            reset_button_n_in <= 1'h0;
            repeat (12) @(posedge core_clk_in);
            reset_button_n_in <= 1'h1;
        end else begin
            other_reset <= 1'h1;
            repeat (4) @(posedge core_clk_in);
            other_reset <= 1'h0;
        end
    endtask : fire
    task lamp_case(input logic [5:0] pins, input logic [5:0] exp);
        @(posedge core_clk_in);
        {board_failure_signal_in, cpu_cycle_status_n_in, lan_bus_master_in} <= pins[5:3];
        {scsi_bus_master_in, vme_master_cycle_in, vme_slave_access_in} <= pins[2:0];
        tick(5);
        chk({fail_lamp_out, controller_role_lamp_out, run_lamp_out, lan_lamp_out, scsi_lamp_out, vme_lamp_out}, exp);
    endtask : lamp_case
    task space(input logic [31:0] a, input logic [1:0] e);
        @(posedge core_clk_in);
        vme_access_addr_in <= a;
        tick(2);
        chk(vme_addr_space_out, e);
    endtask : space
    task timeouts(input logic present, output int n);
        @(posedge core_clk_in);
        slot_present <= present;
        vme_cycle_pending_in <= 1'h1;
        n = 0;
        repeat (4100) begin
            tick(1);
            n += int'(bus_timeout_out === 1'h1);
        end
        @(posedge core_clk_in);
        vme_cycle_pending_in <= 1'h0;
    endtask : timeouts

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'h0;
        meas();
        chk_min(nr, SR);
        chk_min(nd, SR);
        rd_chk(REG_CONTROL, 32'h0);
        wr(REG_STATUS, 32'hFFFFFFFF);
        rd_chk(REG_STATUS, 32'h1);
        rd_chk(4'hC, 32'h0);
        wr(REG_LOC_MON, 32'hA);
        tick(2);
        chk(loc_monitor_out, 4'hA);
        @(posedge core_clk_in);
        ce_in <= 1'h0;
        wr(REG_LOC_MON, 32'h5);
        tick(2);
        chk(loc_monitor_out, 4'hA);
        @(posedge core_clk_in);
        ce_in <= 1'h1;
        rd_chk(REG_LOC_MON, 32'hA);
        lamp_case(6'h2A, 6'h3D);
        lamp_case(6'h15, 6'h13);
        lamp_case(6'h10, 6'h10);
        space(32'hFFFF0000, SPACE_A16);
        space(32'hF0123456, SPACE_A24);
        space(32'hFFFEFFFF, SPACE_A32);
        space(32'h12345678, SPACE_A32);
        for (int s = 0; s < 3; s++) begin
            fork
                meas();
                fire(s);
            join
            chk_min(nr, SR);
            chk_min(nd, SR);
            chk_min(nm, 1);
        end
        wr(REG_CONTROL, 32'h1);
        tick(SR + 10);
        chk(board_reset_out, 1'h1);
        rd_chk(REG_STATUS, 32'h3);
        wr(REG_CONTROL, 32'h0);
        tick(4);
        chk(board_reset_out, 1'h0);
        wr(REG_CONTROL, 32'h1 << CTRL_ABORT_EN);
        @(posedge core_clk_in);
        abort_button_n_in <= 1'h0;
        tick(DB + 8);
        chk(nmi_out, 1'h1);
        rd_chk(REG_STATUS, 32'h9);
        wr(REG_CONTROL, 32'h0);
        tick(3);
        chk(nmi_out, 1'h0);
        @(posedge core_clk_in);
        abort_button_n_in <= 1'h1;
        timeouts(1'h0, nr);
        chk(nr, 1);
        timeouts(1'h1, nr);
        chk(nr, 0);
        sys_ctrl_strap_n_in <= 1'h1;
        lamp_case(6'h10, 6'h00);
        for (int s = 0; s < 4; s++) begin
            fork
                meas();
                fire(s);
            join
            chk(nd, 0);
            chk_min(nr, 1);
            if (s == 2) begin
                chk(nm, 0);
            end
        end
        timeouts(1'h0, nr);
        chk(nr, 0);
        end_sim();
    end

    initial begin
        repeat (30000) @(posedge core_clk_in);
        n_mismatch++;
        end_sim();
    end
endmodule : board_reset_and_panel_control_tb
`default_nettype wire
